// ### fcrp_consts.svh
// Constants for the flash command, reset and protect controller
`ifndef FCRP_CONSTS_SVH
`define FCRP_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define FCRP_CLK_MHZ 25
`define FCRP_CEIL_CYC(ns) (((ns) * `FCRP_CLK_MHZ + 999) / 1000)
`define FCRP_T_SETUP_NS 40
`define FCRP_T_WE_LOW_NS 80
`define FCRP_T_WE_HIGH_NS 40
`define FCRP_T_ACCESS_NS 120
`define FCRP_T_BUSY_NS 100
`define FCRP_T_RESET_PULSE_NS 500
`define FCRP_T_RESET_HIGH_NS 200
`define FCRP_CYC_WE_LOW 8'(`FCRP_CEIL_CYC(`FCRP_T_WE_LOW_NS))
`define FCRP_CYC_WE_HIGH 8'(`FCRP_CEIL_CYC(`FCRP_T_WE_HIGH_NS))
`define FCRP_CYC_ACCESS 8'(`FCRP_CEIL_CYC(`FCRP_T_ACCESS_NS) + 2)
`define FCRP_CYC_BUSY 8'(`FCRP_CEIL_CYC(`FCRP_T_BUSY_NS))
`define FCRP_CYC_RESET_PULSE 8'(`FCRP_CEIL_CYC(`FCRP_T_RESET_PULSE_NS))
`define FCRP_CYC_RESET_HIGH 8'(`FCRP_CEIL_CYC(`FCRP_T_RESET_HIGH_NS))

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define FCRP_REG_CMD 8'h00
`define FCRP_REG_ADDR 8'h04
`define FCRP_REG_WDATA 8'h08
`define FCRP_REG_RDATA 8'h0c
`define FCRP_REG_STATUS 8'h10
`define FCRP_REG_CTRL 8'h14
`define FCRP_ST_REFUSED 2
`define FCRP_ST_INTR 3
`define FCRP_LOCK_PERSIST_BIT 1
`define FCRP_LOCK_PASSWORD_BIT 2

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define FCRP_OP_WRITE 3'h0
`define FCRP_OP_READ 3'h1
`define FCRP_OP_SOFT_RESET 3'h2
`define FCRP_OP_WB_ABORT_RESET 3'h3
`define FCRP_OP_HW_RESET 3'h4
`define FCRP_OP_PROTECT_PROG 3'h5
`define FCRP_OP_LOCK_PROG 3'h6

// ----------------------------------------------------------------
// Flash command words and addresses
// ----------------------------------------------------------------
`define FCRP_CMD_RESET 16'h00f0
`define FCRP_CMD_UNLOCK1 16'h00aa
`define FCRP_CMD_UNLOCK2 16'h0055
`define FCRP_CMD_PROGRAM 16'h00a0
`define FCRP_CMD_PROTECT_SET 16'h0000
`define FCRP_ADDR_UNLOCK1 23'h000555
`define FCRP_ADDR_UNLOCK2 23'h0002aa
`define FCRP_ADDR_LOCK 23'h000000

`endif

// ### fcrp_ctrl.sv
// Host-side command sequencer for an asynchronous parallel NOR flash
//
// Notes on behaviour
// - Command write cycles hold chip and write enable low, output enable high.
// - Host reissues program or erase cut short by a hardware reset; the sequencer only sets intr and leaves the reissue to software.
// - Software reset returns to array read; host uses it after failures.
// - After buffer abort only the abort-reset sequence returns to read.
// - Host programs the password before the password-mode lock bit.
// - Protect bit program carries sector address on SECTOR_SELECT_ADDRESS.
`timescale 1ns/10ps
`include "fcrp_consts.svh"

module fcrp_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Software register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Flash control pins
    output logic flash_ce_b,
    output logic flash_we_b,
    output logic flash_oe_b,
    output logic flash_reset_b,
    output logic [22:0] flash_addr,
    // Flash data pins
    output logic [15:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_i,
    // Flash status pin
    input wire logic ready_busy_out
);

    // ----------------------------------------------------------------
    // Sequence table
    // ----------------------------------------------------------------
    // Address and data of one command cycle of an operation
    function automatic fcrp_pkg::fcrp_cyc_t seq_cycle(
        input logic [2:0] op,
        input logic [1:0] step,
        input logic [22:0] addr,
        input logic [15:0] wdata
    );
        fcrp_pkg::fcrp_cyc_t c;
        c.addr = addr;
        c.data = wdata;
        c.last = 1'b1;
        case (op)
            `FCRP_OP_SOFT_RESET:
                c.data = `FCRP_CMD_RESET;
            `FCRP_OP_WB_ABORT_RESET:
            begin
                c.addr = (step == 2'd1) ? `FCRP_ADDR_UNLOCK2 :
                    `FCRP_ADDR_UNLOCK1;
                c.data = (step == 2'd0) ? `FCRP_CMD_UNLOCK1 :
                    (step == 2'd1) ? `FCRP_CMD_UNLOCK2 :
                    `FCRP_CMD_RESET;
                c.last = (step == 2'd2);
            end
            `FCRP_OP_PROTECT_PROG:
            begin
                // Sector on SECTOR_SELECT_ADDRESS with the program command itself
                c.addr = {addr[22:16], 16'h0000};
                c.data = (step == 2'd0) ? `FCRP_CMD_PROGRAM :
                    `FCRP_CMD_PROTECT_SET;
                c.last = (step == 2'd1);
            end
            `FCRP_OP_LOCK_PROG:
            begin
                c.addr = `FCRP_ADDR_LOCK;
                c.data = (step == 2'd0) ? `FCRP_CMD_PROGRAM : wdata;
                c.last = (step == 2'd1);
            end
            default:
                c.last = 1'b1;
        endcase
        return c;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    fcrp_pkg::fcrp_regs_t r_q;
    fcrp_pkg::fcrp_regs_t r_d;
    fcrp_pkg::fcrp_cyc_t cyc;
    logic start_req;
    logic refuse;
    logic [2:0] new_op;

    assign new_op = reg_wdata[2:0];
    assign start_req = reg_wr && (reg_addr == `FCRP_REG_CMD);
    assign cyc = seq_cycle(r_q.op, r_q.step, r_q.addr, r_q.wdata);

    // Refusal: engine active, flash busy, or unsafe lock program
    always_comb
    begin
        refuse = 1'b0;
        // The engine parks in busy while the flash works; only a
        // hardware reset may cut in there
        if (r_q.st != fcrp_pkg::FCRP_IDLE &&
            !(r_q.st == fcrp_pkg::FCRP_BUSY && new_op == `FCRP_OP_HW_RESET))
            refuse = 1'b1;
        else if (!r_q.rb_s && new_op != `FCRP_OP_HW_RESET)
            refuse = 1'b1;
        else if (new_op == `FCRP_OP_LOCK_PROG &&
                 !r_q.wdata[`FCRP_LOCK_PASSWORD_BIT] && !r_q.pw_done)
            refuse = 1'b1;
        else if (new_op == `FCRP_OP_LOCK_PROG &&
                 !r_q.wdata[`FCRP_LOCK_PASSWORD_BIT] &&
                 !r_q.wdata[`FCRP_LOCK_PERSIST_BIT])
            refuse = 1'b1; // Both bits at once would only abort
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        r_d.rb_m = ready_busy_out;
        r_d.rb_s = r_q.rb_m;
        r_d.dq_m = flash_dq_i;
        r_d.dq_s = r_q.dq_m;
        r_d.bus_rdata = 32'h0000_0000;
        if (r_q.cnt != 8'h00)
            r_d.cnt = r_q.cnt - 8'h01;

        // Register writes; hardware set below wins over clear
        if (reg_wr)
        begin
            case (reg_addr)
                `FCRP_REG_ADDR: r_d.addr = reg_wdata[22:0];
                `FCRP_REG_WDATA: r_d.wdata = reg_wdata[15:0];
                `FCRP_REG_CTRL: r_d.pw_done = reg_wdata[0];
                `FCRP_REG_STATUS:
                begin
                    if (reg_wdata[`FCRP_ST_REFUSED])
                        r_d.refused = 1'b0;
                    if (reg_wdata[`FCRP_ST_INTR])
                        r_d.intr = 1'b0;
                end
                default: r_d.pw_done = r_q.pw_done;
            endcase
        end

        // Register reads, answered in the next cycle
        if (reg_rd)
        begin
            case (reg_addr)
                `FCRP_REG_ADDR: r_d.bus_rdata = {9'h000, r_q.addr};
                `FCRP_REG_WDATA: r_d.bus_rdata = {16'h0000, r_q.wdata};
                `FCRP_REG_RDATA: r_d.bus_rdata = {16'h0000, r_q.rdata};
                `FCRP_REG_STATUS:
                    r_d.bus_rdata = {28'h0000000, r_q.intr, r_q.refused,
                        r_q.rb_s, r_q.st != fcrp_pkg::FCRP_IDLE};
                `FCRP_REG_CTRL: r_d.bus_rdata = {31'h0, r_q.pw_done};
                default: r_d.bus_rdata = 32'h0000_0000;
            endcase
        end

        // Engine
        case (r_q.st)
            fcrp_pkg::FCRP_IDLE:
            begin
                r_d.pins.ce_b = 1'b1;
                r_d.pins.we_b = 1'b1;
                r_d.pins.oe_b = 1'b1;
                r_d.pins.dq_oe = 1'b0;
                if (start_req && !refuse)
                begin
                    r_d.op = new_op;
                    r_d.step = 2'd0;
                    if (new_op == `FCRP_OP_READ)
                    begin
                        r_d.pins.addr = r_q.addr;
                        r_d.pins.ce_b = 1'b0;
                        r_d.pins.oe_b = 1'b0;
                        r_d.cnt = `FCRP_CYC_ACCESS;
                        r_d.st = fcrp_pkg::FCRP_READ;
                    end
                    else
                        r_d.st = fcrp_pkg::FCRP_SETUP;
                end
            end
            fcrp_pkg::FCRP_SETUP:
            begin
                // Address, data and enables launch together; hold follows
                r_d.pins.addr = cyc.addr;
                r_d.pins.dq_o = cyc.data;
                r_d.pins.dq_oe = 1'b1;
                r_d.pins.oe_b = 1'b1;
                r_d.pins.ce_b = 1'b0;
                r_d.pins.we_b = 1'b0;
                r_d.cnt = `FCRP_CYC_WE_LOW;
                r_d.st = fcrp_pkg::FCRP_WE_LOW;
            end
            fcrp_pkg::FCRP_WE_LOW:
            begin
                if (r_q.cnt == 8'h01)
                begin
                    r_d.pins.we_b = 1'b1;
                    r_d.st = fcrp_pkg::FCRP_WE_HIGH;
                end
            end
            fcrp_pkg::FCRP_WE_HIGH:
            begin
                // Data held one cycle past the rising edge
                r_d.pins.ce_b = 1'b1;
                r_d.pins.dq_oe = 1'b0;
                r_d.step = r_q.step + 2'd1;
                if (cyc.last)
                begin
                    r_d.cnt = `FCRP_CYC_BUSY;
                    r_d.st = fcrp_pkg::FCRP_BUSY;
                end
                else
                    r_d.st = fcrp_pkg::FCRP_SETUP;
            end
            fcrp_pkg::FCRP_READ:
            begin
                if (r_q.cnt == 8'h01)
                begin
                    r_d.rdata = r_q.dq_s;
                    r_d.pins.ce_b = 1'b1;
                    r_d.pins.oe_b = 1'b1;
                    r_d.cnt = `FCRP_CYC_WE_HIGH;
                    r_d.st = fcrp_pkg::FCRP_BUSY;
                end
            end
            fcrp_pkg::FCRP_BUSY:
            begin
                // Ready/busy is only trusted after its settling delay
                if (r_q.cnt == 8'h00 && r_q.rb_s)
                    r_d.st = fcrp_pkg::FCRP_IDLE;
            end
            fcrp_pkg::FCRP_RST_LOW:
            begin
                if (r_q.cnt == 8'h01)
                begin
                    r_d.pins.reset_b = 1'b1;
                    r_d.cnt = `FCRP_CYC_RESET_HIGH;
                    r_d.st = fcrp_pkg::FCRP_RST_HIGH;
                end
            end
            fcrp_pkg::FCRP_RST_HIGH:
            begin
                if (r_q.cnt == 8'h00)
                    r_d.st = fcrp_pkg::FCRP_IDLE;
            end
            default:
                r_d.st = fcrp_pkg::FCRP_IDLE;
        endcase

        // Refusal and hardware reset apply in idle and busy alike
        if (start_req && refuse)
            r_d.refused = 1'b1;
        else if (start_req && new_op == `FCRP_OP_HW_RESET)
        begin
            // Cutting a busy flash leaves work to redo
            if (!r_q.rb_s)
                r_d.intr = 1'b1;
            r_d.op = new_op;
            r_d.pins.reset_b = 1'b0;
            r_d.cnt = `FCRP_CYC_RESET_PULSE;
            r_d.st = fcrp_pkg::FCRP_RST_LOW;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Pins park deasserted, flash reset released, ready assumed
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r_q <= '0;
            r_q.st <= fcrp_pkg::FCRP_IDLE;
            r_q.rb_m <= 1'b1;
            r_q.rb_s <= 1'b1;
            r_q.pins.ce_b <= 1'b1;
            r_q.pins.we_b <= 1'b1;
            r_q.pins.oe_b <= 1'b1;
            r_q.pins.reset_b <= 1'b1;
        end
        else
            r_q <= r_d;
    end

    assign reg_rdata = r_q.bus_rdata;
    assign flash_ce_b = r_q.pins.ce_b;
    assign flash_we_b = r_q.pins.we_b;
    assign flash_oe_b = r_q.pins.oe_b;
    assign flash_reset_b = r_q.pins.reset_b;
    assign flash_addr = r_q.pins.addr;
    assign flash_dq_o = r_q.pins.dq_o;
    assign flash_dq_oe = r_q.pins.dq_oe;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_write_pin_levels: assert property (
        @(posedge clk) disable iff (!rst_b)
        !flash_we_b |-> (!flash_ce_b && flash_oe_b && flash_dq_oe))
        else $error("write enable low without proper pin levels");

    a_hw_reset_intr: assert property (
        @(posedge clk) disable iff (!rst_b)
        (start_req && !refuse &&
         new_op == `FCRP_OP_HW_RESET && !r_q.rb_s)
        |=> (r_q.intr && !flash_reset_b))
        else $error("hardware reset on busy flash not flagged");

    a_soft_reset_word: assert property (
        @(posedge clk) disable iff (!rst_b)
        ($fell(flash_we_b) && r_q.op == `FCRP_OP_SOFT_RESET)
        |-> flash_dq_o == `FCRP_CMD_RESET)
        else $error("software reset cycle carries wrong word");

    a_wb_abort_seq: assert property (
        @(posedge clk) disable iff (!rst_b)
        ($fell(flash_we_b) && r_q.op == `FCRP_OP_WB_ABORT_RESET &&
         r_q.step == 2'd2)
        |-> (flash_dq_o == `FCRP_CMD_RESET &&
             flash_addr == `FCRP_ADDR_UNLOCK1))
        else $error("abort reset final cycle wrong");

    a_password_order: assert property (
        @(posedge clk) disable iff (!rst_b)
        (r_q.st == fcrp_pkg::FCRP_IDLE && start_req &&
         new_op == `FCRP_OP_LOCK_PROG && !r_q.pw_done &&
         !r_q.wdata[`FCRP_LOCK_PASSWORD_BIT])
        |=> (r_q.st == fcrp_pkg::FCRP_IDLE && r_q.refused))
        else $error("password lock program not refused");

    a_sector_address: assert property (
        @(posedge clk) disable iff (!rst_b)
        ($fell(flash_we_b) && r_q.op == `FCRP_OP_PROTECT_PROG &&
         flash_dq_o == `FCRP_CMD_PROGRAM)
        |-> flash_addr[22:16] == r_q.addr[22:16])
        else $error("protect program lacks sector address");

    a_no_busy_start: assert property (
        @(posedge clk) disable iff (!rst_b)
        (r_q.st == fcrp_pkg::FCRP_IDLE && !r_q.rb_s)
        |=> (r_q.st == fcrp_pkg::FCRP_IDLE ||
             r_q.st == fcrp_pkg::FCRP_RST_LOW))
        else $error("sequence started while flash busy");

endmodule

// ### fcrp_ctrl_tb.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`include "fcrp_consts.svh"

module fcrp_ctrl_tb;
    typedef struct {logic [31:0] e; logic [31:0] m;} fcrp_note_t;
    localparam logic [31:0] ALL = 32'hffffffff;
    // Register port, flash pins and bookkeeping
    logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, last_rd;
    logic ce_b, we_b, oe_b, frst_b, dq_oe, ry_low, rd_pend = 1'b0;
    logic [22:0] faddr, pa;
    logic [15:0] dq_o, dq_i, m_dq, pd;
    logic [15:0] lk [5] = '{16'hfff9, 16'hfff9, 16'hfffb, 16'hfffb, 16'hfffd};
    logic [4:0] rf = 5'b00111; // Lock words the host must refuse
    fcrp_note_t notes[$];
    fcrp_note_t n;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    wire [31:0] m_addr = {9'h0, flash_u.lat_addr};
    wire [31:0] m_data = {16'h0, flash_u.lat_data};

    always #20 clk = ~clk;
    // Host drives the data bus while writing, the model otherwise
    assign dq_i = dq_oe ? dq_o : m_dq;
    fcrp_ctrl dut_u (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_ce_b(ce_b), .flash_we_b(we_b),
        .flash_oe_b(oe_b), .flash_reset_b(frst_b), .flash_addr(faddr),
        .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i),
        .ready_busy_out(~ry_low)
    );
    fcrp_flash_model flash_u (
        .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .reset_b(frst_b),
        .addr(faddr), .dq_in(dq_i), .dq_out(m_dq), .ry_pull_low(ry_low)
    );

    // Compare and count
    task automatic check(input logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One-cycle write; an idle edge follows so strobes never merge
    task automatic wr(input logic [7:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read; the expected answer and its mask go on the queue
    task automatic rd(input logic [7:0] a, logic [31:0] e, logic [31:0] m);
        notes.push_back('{e, m});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    // Status wait, bounded so a stuck engine cannot hang the run
    task automatic poll(input int b, logic v);
        for (int i = 0; i < 500; i++)
        begin
            rd(`FCRP_REG_STATUS, 32'h0, 32'h0);
            if (last_rd[b] === v)
                return;
        end
        error_cnt++;
        $display("wrong value at %0t: status wait ran out", $time);
    endtask
    task automatic cmd(input logic [2:0] o, logic [22:0] a, logic [15:0] d,
                       bit w);
        wr(`FCRP_REG_ADDR, {9'h0, a});
        wr(`FCRP_REG_WDATA, {16'h0, d});
        wr(`FCRP_REG_CMD, {29'h0, o});
        if (w)
            poll(0, 1'b0);
    endtask
    task automatic prog_word(input logic [22:0] a, logic [15:0] d, bit w);
        cmd(`FCRP_OP_WRITE, `FCRP_ADDR_UNLOCK1, `FCRP_CMD_PROGRAM, 1'b1);
        cmd(`FCRP_OP_WRITE, a, d, w);
    endtask
    task automatic read_back(input logic [22:0] a, logic [15:0] d);
        cmd(`FCRP_OP_READ, a, 16'h0, 1'b1);
        rd(`FCRP_REG_RDATA, {16'h0, d}, ALL);
    endtask

    // Read answers, write-cycle pin levels and the cycle ceiling
    always @(posedge clk)
        rd_pend <= reg_rd;
    always @(negedge clk)
    begin
        cyc++;
        if (rd_pend)
        begin
            n = notes.pop_front();
            last_rd = reg_rdata;
            if (n.m != 32'h0)
                check(reg_rdata & n.m, n.e & n.m);
        end
        if (rst_b && !we_b)
            check({29'h0, ce_b, oe_b, dq_oe}, 32'h3);
        if (cyc == 30000)
        begin
            error_cnt++;
            $display("wrong value at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    initial
    begin
        void'($urandom(80712));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`FCRP_REG_STATUS, 32'h2, ALL);
        rd(8'h1c, 32'h0, ALL);
        pa = 23'($urandom);
        pd = 16'($urandom) | 16'h8000;
        cmd(`FCRP_OP_WRITE, pa, pd, 1'b1);
        check(m_addr, {9'h0, pa});
        check(m_data, {16'h0, pd});
        rd(`FCRP_REG_ADDR, {9'h0, pa}, ALL);
        $display("test reset and write cycle done");
        // Busy device: a new command is refused, then the word reads back
        pa = {7'h01, 16'($urandom)};
        prog_word(pa, pd, 1'b0);
        poll(1, 1'b0);
        wr(`FCRP_REG_CMD, {29'h0, `FCRP_OP_SOFT_RESET});
        rd(`FCRP_REG_STATUS, 32'h4, 32'h6);
        wr(`FCRP_REG_STATUS, 32'h4);
        poll(0, 1'b0);
        read_back(pa, pd);
        $display("test program while busy done");
        // Reset between program cycles cancels it; address is ignored
        pa = {7'h02, 16'($urandom)};
        cmd(`FCRP_OP_WRITE, `FCRP_ADDR_UNLOCK1, `FCRP_CMD_PROGRAM, 1'b1);
        cmd(`FCRP_OP_SOFT_RESET, 23'($urandom), 16'h0, 1'b1);
        check(m_data, {16'h0, `FCRP_CMD_RESET});
        cmd(`FCRP_OP_WRITE, pa, pd, 1'b1);
        read_back(pa, 16'hffff);
        $display("test software reset done");
        // Hardware reset cuts a program short, then it is reissued
        pa = {7'h03, 16'($urandom)};
        prog_word(pa, pd, 1'b0);
        poll(1, 1'b0);
        wr(`FCRP_REG_CMD, {29'h0, `FCRP_OP_HW_RESET});
        poll(0, 1'b0);
        rd(`FCRP_REG_STATUS, 32'ha, 32'hf);
        wr(`FCRP_REG_STATUS, 32'h8);
        read_back(pa, 16'hffff);
        prog_word(pa, pd, 1'b1);
        read_back(pa, pd);
        $display("test hardware reset done");
        // Protect-bit program and the buffer-abort reset sequence
        pa = 23'($urandom) | 23'h400000;
        cmd(`FCRP_OP_PROTECT_PROG, pa, 16'h0, 1'b1);
        check(m_addr, {9'h0, pa[22:16], 16'h0});
        cmd(`FCRP_OP_WB_ABORT_RESET, pa, 16'h0, 1'b1);
        check(m_addr, {9'h0, `FCRP_ADDR_UNLOCK1});
        check(m_data, {16'h0, `FCRP_CMD_RESET});
        $display("test protect and abort reset done");
        // Lock words: both bits, or password bit before password set
        for (int i = 0; i < 5; i++)
        begin
            wr(`FCRP_REG_CTRL, {31'h0, i[0]});
            rd(`FCRP_REG_CTRL, {31'h0, i[0]}, ALL);
            cmd(`FCRP_OP_LOCK_PROG, 23'h0, lk[i], 1'b1);
            rd(`FCRP_REG_STATUS, {29'h0, rf[i], 2'h0}, 32'h4);
            wr(`FCRP_REG_STATUS, 32'h4);
        end
        $display("test lock register done");
        tally_and_finish();
    end
endmodule

// ### fcrp_flash_model.sv
// Behavioural flash device driven through its pins
`timescale 1ns/10ps
`include "fcrp_consts.svh"

module fcrp_flash_model #(
    parameter int PROG_NS = 3000
) (
    // Control pins
    input wire logic ce_b,
    input wire logic we_b,
    input wire logic oe_b,
    input wire logic reset_b,
    // Address and data
    input wire logic [22:0] addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    // Open-drain ready; high pulls the line low
    output logic ry_pull_low
);
    logic [15:0] mem [logic [22:0]];
    logic [22:0] lat_addr = 23'h0;
    logic [15:0] lat_data = 16'h0, val = 16'h0;
    logic armed = 1'b0, busy = 1'b0;
    int tok = 0;

    // Erased words read as all ones
    function automatic logic [15:0] rd_word(input logic [22:0] a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction

    // Commit late, so a reset pulse can still cut the program off
    task automatic prog(input logic [22:0] a, logic [15:0] d, int t);
        #(PROG_NS);
        if (t == tok)
        begin
            mem[a] = rd_word(a) & d;
            busy = 1'b0;
        end
    endtask

    // Address on the later falling enable; a short wait lets the
    // address pins launched on the same edge settle first
    always @(negedge we_b or negedge ce_b)
    begin
        #1;
        if (!we_b && !ce_b && reset_b)
            lat_addr = addr;
    end
    // Data on the first rising enable; commands dropped while busy
    always @(posedge we_b or posedge ce_b)
        if ((we_b ^ ce_b) && reset_b && !busy)
        begin
            lat_data = dq_in;
            if (lat_data == `FCRP_CMD_RESET)
                armed = 1'b0;
            else if (armed)
            begin
                armed = 1'b0;
                busy = 1'b1;
                fork
                    prog(lat_addr, lat_data, tok);
                join_none
            end
            else if (lat_data == `FCRP_CMD_PROGRAM)
                armed = 1'b1;
        end
    // Reset pin aborts all work and goes back to array read
    always @(negedge reset_b)
    begin
        tok++;
        busy = 1'b0;
        armed = 1'b0;
    end
    // Read path; a released bus shows the inverse of the last word
    always @*
        if (!ce_b && !oe_b && reset_b)
            val = rd_word(addr);
    assign #100 dq_out = (!ce_b && !oe_b && reset_b) ? val : ~val;
    assign ry_pull_low = busy;
endmodule

// ### fcrp_pkg.sv
// Types for the flash command, reset and protect controller
package fcrp_pkg;

    // One-hot engine states
    typedef enum logic [7:0] {
        FCRP_IDLE = 8'h01,
        FCRP_SETUP = 8'h02,
        FCRP_WE_LOW = 8'h04,
        FCRP_WE_HIGH = 8'h08,
        FCRP_READ = 8'h10,
        FCRP_BUSY = 8'h20,
        FCRP_RST_LOW = 8'h40,
        FCRP_RST_HIGH = 8'h80
    } fcrp_state_t;

    // Flash pin outputs
    typedef struct packed {
        logic ce_b;
        logic we_b;
        logic oe_b;
        logic reset_b;
        logic [22:0] addr;
        logic [15:0] dq_o;
        logic dq_oe;
    } fcrp_pins_t;

    // One command cycle of a sequence
    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] data;
        logic last;
    } fcrp_cyc_t;

    // Whole controller state
    typedef struct packed {
        fcrp_state_t st;
        logic [7:0] cnt;
        logic [1:0] step;
        logic [2:0] op;
        logic [22:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic pw_done;
        logic refused;
        logic intr;
        logic rb_m;
        logic rb_s;
        logic [15:0] dq_m;
        logic [15:0] dq_s;
        fcrp_pins_t pins;
        logic [31:0] bus_rdata;
    } fcrp_regs_t;

endpackage
